// [hw/adc_device_end.sv]
// Converter end: power-up calibration, conversion control, serial out.
// Assumes the host makes sclk and keeps the link quiet until calibrated.
//
// Operation
// - Calibration starts about 40 ms after power
// - Calibration lasts about 400 ms
// - Hot calibration may take 55 ms longer
// - Host keeps link quiet before and during calibration
// - Host waits 450-500 ms after power-on
// - Otherwise host may need manual recalibration
// - Enter acquisition alone once calibration ends
// - No serial output marks calibration end
// - Rising start edge begins a conversion
// - Conversion timed by the internal clock
// - Return to acquisition when conversion ends
// - Host reads result during acquisition with its clock
// - Unipolar straight binary, zero input gives zero
// - Saturate to all ones or all zeros
// - Data only after select low post conversion
// - Shift result out MSB first on sclk
// - Host holds serial data input high
`timescale 1ns/100ps
module adc_device_end #(
  parameter int unsigned RESULT_BITS = adc_pkg::RESULT_BITS_HI,
  parameter int unsigned POWERUP_DELAY_CYCLES =
    adc_pkg::POWERUP_DELAY_CYCLES,
  parameter int unsigned CAL_CYCLES = adc_pkg::CAL_CYCLES,
  parameter int unsigned CAL_EXTRA_CYCLES = 0,
  parameter int unsigned CONVERSION_CYCLES = adc_pkg::CONVERSION_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  adc_link_if.device link,
  input wire logic signed [RESULT_BITS+1:0] analog_in,
  output logic calibrating,
  output logic acquiring,
  output logic converting,
  output logic start_ignored
);
  localparam int unsigned W = RESULT_BITS;
  localparam int unsigned BW = $clog2(W + 1);

  // Internal clock domain
  typedef struct packed {
    adc_pkg::dev_state_e st;
    adc_pkg::cnt_t cnt;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic [W-1:0] held;
    logic [W-1:0] result;
    logic tog;
    logic link_rst;
    logic calibrating;
    logic acquiring;
    logic converting;
    logic start_ignored;
  } core_s;

  // Serial clock domain
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic cs1;
    logic cs2;
    logic t1;
    logic t2;
    logic seen;
    logic armed;
    logic [BW-1:0] bits;
    logic [W-1:0] shreg;
    logic sdo;
  } link_s;

  core_s c_q;
  core_s c_d;
  link_s l_q;
  link_s l_d;
  logic start_rise;

  assign start_rise = c_q.cs_s2 && !c_q.cs_s3;
  assign calibrating = c_q.calibrating;
  assign acquiring = c_q.acquiring;
  assign converting = c_q.converting;
  assign start_ignored = c_q.start_ignored;
  assign link.sdo = l_q.sdo;

  always_comb begin
    c_d = c_q;
    c_d.cs_s1 = link.conversion_start_select;
    c_d.cs_s2 = c_q.cs_s1;
    c_d.cs_s3 = c_q.cs_s2;
    c_d.start_ignored = 1'b0;
    unique case (c_q.st)
      adc_pkg::DEV_POWER_WAIT: begin
        // Power-on delay, then self calibration
        if (c_q.cnt == '0) begin
          c_d.st = adc_pkg::DEV_CALIBRATE;
          c_d.cnt = adc_pkg::cnt_t'(CAL_CYCLES + CAL_EXTRA_CYCLES - 1);
        end else begin
          c_d.cnt = c_q.cnt - 1'b1;
        end
      end
      adc_pkg::DEV_CALIBRATE: begin
        // Nominal plus hot extension
        if (c_q.cnt == '0) begin
          // Silent move to acquisition
          c_d.st = adc_pkg::DEV_ACQUIRE;
        end else begin
          c_d.cnt = c_q.cnt - 1'b1;
        end
      end
      adc_pkg::DEV_ACQUIRE: begin
        if (start_rise) begin
          // Sample and begin conversion
          c_d.st = adc_pkg::DEV_CONVERT;
          c_d.cnt = adc_pkg::cnt_t'(CONVERSION_CYCLES - 1);
          if (analog_in[W+1] || analog_in == '0) begin
            c_d.held = '0;
          end else if (analog_in[W]) begin
            c_d.held = '1;
          end else begin
            c_d.held = analog_in[W-1:0];
          end
        end
      end
      adc_pkg::DEV_CONVERT: begin
        // Internal clock times the conversion
        if (c_q.cnt == '0) begin
          c_d.result = c_q.held;
          c_d.tog = ~c_q.tog;
          c_d.link_rst = 1'b0;
          c_d.st = adc_pkg::DEV_ACQUIRE;
        end else begin
          c_d.cnt = c_q.cnt - 1'b1;
        end
        // Early start edge is dropped
        c_d.start_ignored = start_rise;
      end
    endcase
    c_d.calibrating = (c_d.st == adc_pkg::DEV_POWER_WAIT) ||
                      (c_d.st == adc_pkg::DEV_CALIBRATE);
    c_d.acquiring = (c_d.st == adc_pkg::DEV_ACQUIRE);
    c_d.converting = (c_d.st == adc_pkg::DEV_CONVERT);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      c_q <= '{st: adc_pkg::DEV_POWER_WAIT,
               cnt: adc_pkg::cnt_t'(POWERUP_DELAY_CYCLES - 1),
               calibrating: 1'b1,
               link_rst: 1'b1,
               default: '0};
    end else begin
      c_q <= c_d;
    end
  end

  always_comb begin
    l_d = l_q;
    // Link side cleared until first result, while sclk surely runs
    l_d.rs1 = c_q.link_rst;
    l_d.rs2 = l_q.rs1;
    l_d.cs1 = link.conversion_start_select;
    l_d.cs2 = l_q.cs1;
    l_d.t1 = c_q.tog;
    l_d.t2 = l_q.t1;
    if (l_q.rs2) begin
      l_d.seen = 1'b0;
      l_d.armed = 1'b0;
      l_d.bits = '0;
      l_d.sdo = 1'b0;
    end else if (l_q.cs2) begin
      l_d.bits = '0;
      l_d.sdo = 1'b0;
      // Fresh result is stable once its toggle has crossed
      if (l_q.t2 != l_q.seen) begin
        l_d.seen = l_q.t2;
        l_d.shreg = c_q.result;
        l_d.armed = 1'b1;
      end
    end else if (l_q.armed) begin
      // Select low after completion releases data
      l_d.sdo = l_q.shreg[W-1];
      l_d.shreg = {l_q.shreg[W-2:0], 1'b0};
      l_d.bits = l_q.bits + 1'b1;
      if (l_q.bits == BW'(W - 1)) begin
        l_d.armed = 1'b0;
      end
    end else begin
      l_d.sdo = 1'b0;
    end
  end

  always_ff @(posedge link.sclk) begin
    l_q <= l_d;
  end
endmodule

// [hw/adc_host_end.sv]
// Host controller end: waits out calibration, starts and reads conversions.
// Assumes the converter end of the link and a consumer on the FIFO output.
`timescale 1ns/100ps
module adc_host_end #(
  parameter int unsigned RESULT_BITS = adc_pkg::RESULT_BITS_HI,
  parameter int unsigned HOST_WAIT_CYCLES = adc_pkg::HOST_WAIT_CYCLES,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  adc_link_if.host link,
  input wire logic run,
  output logic link_ready,
  output logic [RESULT_BITS-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready
);
  localparam int unsigned W = RESULT_BITS;
  localparam int unsigned DW = $clog2(adc_pkg::SCLK_HALF_CYCLES);
  localparam logic [5:0] FIRST_BIT = 6'(adc_pkg::LINK_LEAD_EDGES);
  localparam logic [5:0] LAST_EDGE = 6'(adc_pkg::LINK_LEAD_EDGES + W);

  typedef struct packed {
    adc_pkg::host_state_e st;
    adc_pkg::cnt_t cnt;
    logic [DW-1:0] div;
    logic sclk;
    logic cs;
    logic sdo_s1;
    logic sdo_s2;
    logic [5:0] edges;
    logic [W-1:0] shreg;
    logic push;
    logic ready;
  } host_s;

  host_s q;
  host_s d;
  logic half;
  logic rise;
  logic fall;
  logic in_ready;

  assign half = (q.div == DW'(adc_pkg::SCLK_HALF_CYCLES - 1));
  assign rise = half && !q.sclk;
  assign fall = half && q.sclk;
  assign link.sclk = q.sclk;
  assign link.conversion_start_select = q.cs;
  assign link.sdi = 1'b1;
  assign link_ready = q.ready;

  always_comb begin
    d = q;
    d.sdo_s1 = link.sdo;
    d.sdo_s2 = q.sdo_s1;
    if (q.st != adc_pkg::HOST_POWER_WAIT) begin
      d.div = half ? '0 : q.div + 1'b1;
      d.sclk = half ? ~q.sclk : q.sclk;
    end
    unique case (q.st)
      adc_pkg::HOST_POWER_WAIT: begin
        // Link held quiet until calibration surely done
        // No recalibration path, so the wait is always kept
        if (q.cnt == '0) begin
          d.st = adc_pkg::HOST_IDLE;
          d.ready = 1'b1;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      adc_pkg::HOST_IDLE: begin
        if (fall && run) begin
          d.st = adc_pkg::HOST_CONVERT;
          d.cs = 1'b1;
          d.cnt = adc_pkg::cnt_t'(adc_pkg::CONV_WAIT_PERIODS - 1);
        end
      end
      adc_pkg::HOST_CONVERT: begin
        // Hold off until conversion time has passed
        if (fall) begin
          if (q.cnt == '0) begin
            d.st = adc_pkg::HOST_READ;
            d.cs = 1'b0;
            d.edges = '0;
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
      end
      adc_pkg::HOST_READ: begin
        // Read in acquisition with own clock
        if (rise) begin
          if (q.edges >= FIRST_BIT && q.edges < LAST_EDGE) begin
            d.shreg = {q.shreg[W-2:0], q.sdo_s2};
          end
          d.edges = q.edges + 1'b1;
        end
        if (fall && q.edges == LAST_EDGE) begin
          d.st = adc_pkg::HOST_PUSH;
          d.push = 1'b1;
        end
      end
      adc_pkg::HOST_PUSH: begin
        if (in_ready) begin
          d.st = adc_pkg::HOST_IDLE;
          d.push = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '{st: adc_pkg::HOST_POWER_WAIT,
             cnt: adc_pkg::cnt_t'(HOST_WAIT_CYCLES - 1),
             default: '0};
    end else begin
      q <= d;
    end
  end

  sample_fifo #(
    .WIDTH(W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_data(q.shreg),
    .in_valid(q.push),
    .in_ready(in_ready),
    .out_data(word_data),
    .out_valid(word_valid),
    .out_ready(word_ready)
  );
endmodule

// [hw/adc_link_if.sv]
// Four-wire serial link between converter and host controller.
// Assumes the host makes sclk; the converter only listens to it.
`timescale 1ns/100ps
interface adc_link_if;
  logic sclk;
  logic conversion_start_select;
  logic sdo;
  logic sdi;

  modport device (
    input sclk,
    input conversion_start_select,
    input sdi,
    output sdo
  );

  modport host (
    output sclk,
    output conversion_start_select,
    output sdi,
    input sdo
  );
endinterface

// [hw/adc_pkg.sv]
// Shared constants and types for the converter link and both ends.
// Assumes a 40 MHz core clock at each end and a host-made serial clock.
package adc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;

  // Result widths of the two variants
  localparam int unsigned RESULT_BITS_HI = 14;
  localparam int unsigned RESULT_BITS_LO = 12;

  // Power-up timing
  localparam int unsigned POWERUP_DELAY_MS = 40;
  localparam int unsigned CAL_TIME_MS = 400;
  localparam int unsigned CAL_HOT_EXTRA_MS = 55;
  localparam int unsigned HOST_WAIT_MS = 500;
  localparam int unsigned POWERUP_DELAY_CYCLES =
    POWERUP_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CAL_CYCLES = CAL_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CAL_HOT_EXTRA_CYCLES =
    CAL_HOT_EXTRA_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HOST_WAIT_CYCLES =
    (HOST_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Conversion timing, internal clock
  localparam int unsigned CONVERSION_TIME_NS = 700;
  localparam int unsigned CONVERSION_CYCLES =
    (CONVERSION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Serial clock made by the host
  localparam int unsigned SCLK_HALF_CYCLES = 4;
  localparam int unsigned SCLK_PERIOD_NS =
    2 * SCLK_HALF_CYCLES * CLK_PERIOD_NS;
  // Rising edges after select low before the first bit appears
  localparam int unsigned LINK_LEAD_EDGES = 3;
  // Serial periods the host holds start high per conversion
  localparam int unsigned CONV_WAIT_PERIODS =
    (CONVERSION_TIME_NS + 4 * CLK_PERIOD_NS + SCLK_PERIOD_NS - 1)
    / SCLK_PERIOD_NS + 4;

  localparam int unsigned COUNT_W = 25;
  typedef logic [COUNT_W-1:0] cnt_t;

  typedef enum logic [3:0] {
    DEV_POWER_WAIT = 4'h1,
    DEV_CALIBRATE = 4'h2,
    DEV_ACQUIRE = 4'h4,
    DEV_CONVERT = 4'h8
  } dev_state_e;

  typedef enum logic [4:0] {
    HOST_POWER_WAIT = 5'h01,
    HOST_IDLE = 5'h02,
    HOST_CONVERT = 5'h04,
    HOST_READ = 5'h08,
    HOST_PUSH = 5'h10
  } host_state_e;

endpackage

// [hw/sample_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module sample_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] count;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic push;
  logic pop;

  assign in_ready = (q.count != CW'(DEPTH));
  assign out_valid = (q.count != '0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.count = q.count + 1'b1;
    end else if (pop && !push) begin
      d.count = q.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// [sim/adc_link_asserts.sv]
// Checker on the wire signals of the converter link.
// Assumes both ends share clk and the host makes sclk.
`timescale 1ns/100ps
module adc_link_asserts #(
  parameter int unsigned RESULT_BITS = 14,
  parameter int unsigned HOST_WAIT_CYCLES = 100
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic conversion_start_select,
  input wire logic sdo,
  input wire logic sdi
);
  localparam int CONV_MIN = 31;
  logic quiet_done;
  logic seen_q;
  logic sclk_q;
  int cyc_q;
  int hi_q;
  int rise_q;
  assign quiet_done = cyc_q >= int'(HOST_WAIT_CYCLES) - 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Power wait, select-high and frame counters
  always_ff @(posedge clk) begin
    if (reset) begin
      cyc_q <= 0;
      hi_q <= 0;
      rise_q <= 0;
      sclk_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      cyc_q <= quiet_done ? cyc_q : cyc_q + 1;
      hi_q <= conversion_start_select ? hi_q + 1 : 0;
      rise_q <= conversion_start_select ? 0 : rise_q + int'(sclk && !sclk_q);
      sclk_q <= sclk;
      seen_q <= seen_q || $fell(conversion_start_select);
    end
  end
  a_sdi_held_high: assert property (sdi)
    else $error("sdi not held high");
  a_quiet_power_wait: assert property (
    !quiet_done |-> !sclk && !conversion_start_select)
    else $error("link active during power wait");
  a_sclk_half_period: assert property (
    $rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("sclk half period wrong");
  a_start_hold_time: assert property (
    $fell(conversion_start_select) |-> hi_q >= CONV_MIN)
    else $error("select lowered before conversion end");
  a_sdo_quiet_select: assert property (
    seen_q && conversion_start_select |-> !sdo)
    else $error("sdo active while select high");
  a_sdo_lead_zero: assert property (
    seen_q && $fell(conversion_start_select) |-> !sdo[*8])
    else $error("sdo active too early in frame");
  a_sdo_on_rise: assert property (
    seen_q && $changed(sdo) |-> $rose(sclk))
    else $error("sdo changed off a rising sclk");
  a_frame_rises: assert property (
    seen_q && $rose(conversion_start_select) |-> rise_q >= RESULT_BITS + 2)
    else $error("frame too short for result");
  c_start: cover property ($rose(conversion_start_select));
  c_read: cover property ($fell(conversion_start_select));
  c_data_one: cover property (seen_q && $rose(sdo));
endmodule

// [sim/adc_powerup_cal_conversion_control_test.sv]
// Testbench joining host end and converter end over the link.
// Assumes one 40 MHz clock for both ends; host makes sclk.
`timescale 1ns/100ps
module adc_powerup_cal_conversion_control_test;
  localparam int unsigned W = adc_pkg::RESULT_BITS_HI;
  localparam int unsigned PWR = 20;
  localparam int unsigned CAL = 50;
  localparam int unsigned HWAIT = 100;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic signed [W+1:0] analog_in = '0;
  logic run = 1'b0;
  logic word_ready = 1'b0;
  logic calibrating, acquiring, converting, link_ready, word_valid;
  logic [W-1:0] word_data;
  int fail_count = 0;
  int samples_checked = 0;
  int vals[7] = '{-5, 0, 1, 32'h2a5c, 32'h3fff, 32'h4000, 32'h4e20};
  always #12.5 clk = ~clk;
  adc_link_if link ();
  adc_device_end #(.RESULT_BITS(W), .POWERUP_DELAY_CYCLES(PWR),
    .CAL_CYCLES(CAL)) i_adc_device_end (.clk(clk), .reset(reset),
    .link(link), .analog_in(analog_in), .calibrating(calibrating),
    .acquiring(acquiring), .converting(converting), .start_ignored());
  adc_host_end #(.RESULT_BITS(W), .HOST_WAIT_CYCLES(HWAIT))
    i_adc_host_end (.clk(clk), .reset(reset), .link(link), .run(run),
    .link_ready(link_ready), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready));
  adc_link_asserts #(.RESULT_BITS(W), .HOST_WAIT_CYCLES(HWAIT))
    i_adc_link_asserts (.clk(clk), .reset(reset), .sclk(link.sclk),
    .conversion_start_select(link.conversion_start_select),
    .sdo(link.sdo), .sdi(link.sdi));
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Waits for a word, then pops it
  task automatic get_word(output logic [W-1:0] w, output bit ok);
    int n;
    n = 0;
    @(negedge clk);
    while (word_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    ok = word_valid === 1'b1;
    w = word_data;
    @(posedge clk);
    word_ready <= ok;
    @(posedge clk);
    word_ready <= 1'b0;
  endtask
  function automatic logic [W-1:0] code_of(input int v);
    if (v <= 0) begin
      return '0;
    end
    if (v > 2 ** W - 1) begin
      return '1;
    end
    return v[W-1:0];
  endfunction
  initial begin
    logic [W-1:0] w;
    bit ok;
    int n;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    n = 0;
    @(negedge clk);
    while (calibrating === 1'b1 && n < 1000) begin
      check("acquiring in cal", acquiring, 1'b0);
      n++;
      @(negedge clk);
    end
    ok = n >= PWR + CAL && n <= PWR + CAL + 2;
    check("cal length", ok, 1'b1);
    check("acquiring after cal", acquiring, 1'b1);
    check("host still waiting", link_ready, 1'b0);
    foreach (vals[i]) begin
      @(posedge clk);
      analog_in <= (W+2)'(vals[i]);
      run <= 1'b1;
      n = 0;
      while (converting !== 1'b1 && n < 4000) begin
        @(negedge clk);
        n++;
      end
      check("link ready", link_ready, 1'b1);
      n = 0;
      while (converting === 1'b1 && n < 100) begin
        check("acquiring in conv", acquiring, 1'b0);
        n++;
        @(negedge clk);
      end
      check("conv cycles", n, adc_pkg::CONVERSION_CYCLES);
      check("back to acq", acquiring, 1'b1);
      @(posedge clk);
      run <= 1'b0;
      get_word(w, ok);
      check("code", w, code_of(vals[i]));
      repeat (300) @(negedge clk);
      check("one word per start", word_valid, 1'b0);
    end
    @(posedge clk);
    analog_in <= (W+2)'(32'h155);
    run <= 1'b1;
    repeat (6000) @(posedge clk);
    run <= 1'b0;
    n = 0;
    ok = 1'b1;
    while (ok) begin
      get_word(w, ok);
      if (ok) begin
        check("burst word", w, 14'h155);
        n++;
      end
    end
    check("burst count", n, 17);
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
